// ### scd_pkg.sv
package scd_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_MAIN = 8'h00;
  localparam logic [7:0] OFF_OPT  = 8'h04;
  localparam logic [7:0] OFF_BAUD = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_DATA = 8'h10;

  // ----------------------------------------------------------------
  // field positions and write masks
  // ----------------------------------------------------------------
  localparam int OC_MFEN  = 4;
  localparam int OC_BIDIR = 3;
  localparam int OC_SIW   = 1;
  localparam int OC_SWS   = 0;
  localparam logic [7:0] OC_MASK = 8'h1B;
  localparam int BR_PRE_LO  = 4;
  localparam int BR_RATE_LO = 0;
  localparam logic [7:0] BR_MASK = 8'h77;
  localparam int ST_RXF = 7;
  localparam int ST_TXE = 5;
  localparam int ST_MF  = 4;

  // ----------------------------------------------------------------
  // reset values and transfer timing
  // ----------------------------------------------------------------
  localparam logic [7:0] MAIN_RST = 8'h00;
  localparam logic [7:0] OPT_RST  = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [3:0] LAST_EDGE = 4'hF;  // sixteen clock edges, eight bits
  localparam int TX_RELOAD_CYC = 2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rx_fault_int_enable;
    logic system_enable;
    logic tx_int_enable;
    logic master_select;
    logic clk_polarity;
    logic clk_phase;
    logic select_output_enable;
    logic lsb_first;
  } scd_main_s;

  typedef struct packed {
    logic o;
    logic oe;
  } scd_pin_s;

  typedef enum {st_idle, st_run} scd_state_e;

  // bit that leaves the shifter first
  function automatic logic scd_front(input logic [7:0] d, input logic lsbf);
    return lsbf ? d[0] : d[7];
  endfunction

  // shift one received bit in at the far end
  function automatic logic [7:0] scd_shift_in(input logic [7:0] d, input logic b, input logic lsbf);
    return lsbf ? {b, d[7:1]} : {d[6:0], b};
  endfunction

endpackage

// ### scd_serial_regs.sv
module scd_serial_regs
  import scd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        wait_mode,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe,
  input  wire logic        ss_n_in,
  output logic             ss_n_out,
  output logic             ss_n_oe,
  output logic             irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  scd_main_s  main_ctl, next_main_ctl;
  logic [7:0] opt, next_opt, baud, next_baud;
  logic [7:0] rx_buf, next_rx_buf, tx_buf, next_tx_buf;
  logic       rx_full, next_rx_full, tx_empty, next_tx_empty;
  logic       mode_fault, next_mode_fault;
  logic       arm_rx, next_arm_rx, arm_tx, next_arm_tx, arm_mf, next_arm_mf;
  logic [31:0] next_prdata;
  logic       next_pready, next_pslverr, next_irq;
  scd_state_e state, next_state;
  logic [7:0] shifter, next_shifter;
  logic       out_bit, next_out_bit, sck_lvl, next_sck_lvl;
  logic [3:0] edge_cnt, next_edge_cnt;
  logic [2:0] pre_cnt, next_pre_cnt;
  logic [6:0] rate_cnt, next_rate_cnt;
  logic       sck_q, sck_q2, ss_q, ss_q2;
  scd_pin_s   next_sck, next_mosi, next_miso, next_ss;

  // ----------------------------------------------------------------
  // shared decode
  // ----------------------------------------------------------------
  logic       en, mst, cpol, cpha, lsbf, sws, bidir, mfen, run_ok;
  logic [2:0] pre, rate;
  logic [6:0] half_lim;
  logic       half_tick, m_edge, s_edge, edge_ev, lead, sample_ev, din;
  logic [7:0] shifted;
  logic       eng_load, eng_done;
  logic [7:0] eng_rx_byte;
  logic       acc_fin;
  assign en        = main_ctl.system_enable;
  assign mst       = main_ctl.master_select;
  assign cpol      = main_ctl.clk_polarity;
  assign cpha      = main_ctl.clk_phase;
  assign lsbf      = main_ctl.lsb_first;
  assign sws       = opt[OC_SWS];
  assign bidir     = opt[OC_BIDIR];
  assign mfen      = opt[OC_MFEN];
  assign run_ok    = en && !(wait_mode && opt[OC_SIW]);
  assign pre       = baud[BR_PRE_LO+2:BR_PRE_LO];
  assign rate      = baud[BR_RATE_LO+2:BR_RATE_LO];
  // half bit time is (pre+1) * 2^rate bus cycles
  assign half_lim  = 7'((8'h01 << rate) - 8'h01);
  assign half_tick = (pre_cnt == pre) && (rate_cnt == half_lim);
  assign m_edge    = (state == st_run) && mst && half_tick;
  assign s_edge    = !mst && !ss_q && (sck_q != sck_q2);
  assign edge_ev   = m_edge || s_edge;
  assign lead      = mst ? !edge_cnt[0] : (sck_q != cpol);
  assign sample_ev = lead ^ cpha;  // phase 0 samples on leading edges
  assign din       = mst ? (sws ? mosi_in : miso_in) : (sws ? miso_in : mosi_in);
  assign shifted   = scd_shift_in(shifter, din, lsbf);
  assign acc_fin   = psel && penable && pready;

  // ----------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------
  // slave edges come from the sampled clock pin, so that clock must stay well below the bus clock
  always_comb begin
    next_state    = state;
    next_shifter  = shifter;
    next_out_bit  = out_bit;
    next_sck_lvl  = sck_lvl;
    next_edge_cnt = edge_cnt;
    next_pre_cnt  = pre_cnt;
    next_rate_cnt = rate_cnt;
    eng_load      = 1'b0;
    eng_done      = 1'b0;
    eng_rx_byte   = shifter;
    if (!en) begin
      next_state    = st_idle;
      next_sck_lvl  = 1'b0;
      next_edge_cnt = 4'h0;
      next_pre_cnt  = 3'h0;
      next_rate_cnt = 7'h00;
    end else if (run_ok) begin
      if (state == st_run && mst) begin
        if (pre_cnt == pre) begin
          next_pre_cnt  = 3'h0;
          next_rate_cnt = half_tick ? 7'h00 : rate_cnt + 7'h01;
        end else begin
          next_pre_cnt = pre_cnt + 3'h1;
        end
      end
      if (edge_ev) begin
        next_state    = st_run;
        next_edge_cnt = edge_cnt + 4'h1;
        next_sck_lvl  = mst ? !sck_lvl : sck_lvl;
        if (sample_ev) begin
          next_shifter = shifted;
        end else begin
          next_out_bit = scd_front(shifter, lsbf);
        end
        if (edge_cnt == LAST_EDGE) begin
          eng_done      = 1'b1;
          eng_rx_byte   = sample_ev ? shifted : shifter;
          next_state    = st_idle;
          next_edge_cnt = 4'h0;
          next_sck_lvl  = 1'b0;
          next_pre_cnt  = 3'h0;
          next_rate_cnt = 7'h00;
        end
      end else if (!mst && ss_q) begin
        // deselect mid-byte drops the partial byte
        next_state    = st_idle;
        next_edge_cnt = 4'h0;
      end else if (state == st_idle && !tx_empty) begin
        eng_load     = 1'b1;
        next_shifter = tx_buf;
        next_out_bit = scd_front(tx_buf, lsbf);
        if (mst) begin
          next_state = st_run;
        end
      end else if (!mst && !cpha && ss_q2 && !ss_q) begin
        next_out_bit = scd_front(shifter, lsbf);
      end
    end
  end

  // engine registers and pin samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= st_idle;
      shifter  <= 8'h00;
      out_bit  <= 1'b0;
      sck_lvl  <= 1'b0;
      edge_cnt <= 4'h0;
      pre_cnt  <= 3'h0;
      rate_cnt <= 7'h00;
      sck_q    <= 1'b0;
      sck_q2   <= 1'b0;
      ss_q     <= 1'b1;
      ss_q2    <= 1'b1;
    end else begin
      state    <= next_state;
      shifter  <= next_shifter;
      out_bit  <= next_out_bit;
      sck_lvl  <= next_sck_lvl;
      edge_cnt <= next_edge_cnt;
      pre_cnt  <= next_pre_cnt;
      rate_cnt <= next_rate_cnt;
      sck_q    <= sck_in;
      sck_q2   <= sck_q;
      ss_q     <= ss_n_in;
      ss_q2    <= ss_q;
    end
  end

  // ----------------------------------------------------------------
  // registers, flags and apb slave
  // ----------------------------------------------------------------
  // one wait state: prdata is captured in the first access cycle, and a status read arms on that value
  always_comb begin
    logic [7:0] rd_val;
    logic       mapped;
    rd_val          = 8'h00;
    mapped          = 1'b1;
    next_main_ctl   = main_ctl;
    next_opt        = opt;
    next_baud       = baud;
    next_rx_buf     = rx_buf;
    next_tx_buf     = tx_buf;
    next_rx_full    = rx_full;
    next_tx_empty   = tx_empty;
    next_mode_fault = mode_fault;
    next_arm_rx     = arm_rx;
    next_arm_tx     = arm_tx;
    next_arm_mf     = arm_mf;
    next_pready     = psel && penable && !pready;
    case (paddr)
      OFF_MAIN: rd_val = main_ctl;
      OFF_OPT:  rd_val = opt & OC_MASK;
      OFF_BAUD: rd_val = baud;
      OFF_STAT: begin
        rd_val[ST_RXF] = rx_full;
        rd_val[ST_TXE] = tx_empty;
        rd_val[ST_MF]  = mode_fault;
      end
      OFF_DATA: rd_val = rx_buf;
      default:  mapped = 1'b0;
    endcase
    next_pslverr = next_pready && !mapped;
    next_prdata  = next_pready ? {24'h000000, rd_val} : prdata;
    // clears first, so that hardware sets below win
    if (acc_fin && pwrite) begin
      case (paddr)
        OFF_MAIN: begin
          next_main_ctl = pwdata[7:0];
          if (arm_mf) begin
            next_mode_fault = 1'b0;
            next_arm_mf     = 1'b0;
          end
        end
        OFF_OPT:  next_opt  = pwdata[7:0] & OC_MASK;
        OFF_BAUD: next_baud = pwdata[7:0] & BR_MASK;
        OFF_DATA: begin
          if (arm_tx && tx_empty) begin
            next_tx_buf   = pwdata[7:0];
            next_tx_empty = 1'b0;
            next_arm_tx   = 1'b0;
          end
        end
        default: ;  // status writes fall here and change nothing
      endcase
    end
    if (acc_fin && !pwrite && paddr == OFF_STAT) begin
      next_arm_rx = arm_rx || prdata[ST_RXF];
      next_arm_tx = arm_tx || prdata[ST_TXE];
      next_arm_mf = arm_mf || prdata[ST_MF];
    end
    if (acc_fin && !pwrite && paddr == OFF_DATA && arm_rx) begin
      next_rx_full = 1'b0;
      next_arm_rx  = 1'b0;
    end
    next_tx_empty = next_tx_empty || eng_load;
    if (eng_done && !next_rx_full) begin
      next_rx_buf = eng_rx_byte;
    end
    next_rx_full    = next_rx_full || eng_done;
    next_mode_fault = next_mode_fault || (en && mst && mfen && !main_ctl.select_output_enable && !ss_q);
    if (!en) begin
      next_rx_full  = 1'b0;
      next_tx_empty = 1'b1;
    end
    next_irq = (main_ctl.tx_int_enable && tx_empty)
            || (main_ctl.rx_fault_int_enable && (rx_full || mode_fault));
  end

  // register file and bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_ctl   <= MAIN_RST;
      opt        <= OPT_RST;
      baud       <= BAUD_RST;
      rx_buf     <= 8'h00;
      tx_buf     <= 8'h00;
      rx_full    <= 1'b0;
      tx_empty   <= 1'b1;
      mode_fault <= 1'b0;
      arm_rx     <= 1'b0;
      arm_tx     <= 1'b0;
      arm_mf     <= 1'b0;
      prdata     <= 32'h00000000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      irq        <= 1'b0;
    end else begin
      main_ctl   <= next_main_ctl;
      opt        <= next_opt;
      baud       <= next_baud;
      rx_buf     <= next_rx_buf;
      tx_buf     <= next_tx_buf;
      rx_full    <= next_rx_full;
      tx_empty   <= next_tx_empty;
      mode_fault <= next_mode_fault;
      arm_rx     <= next_arm_rx;
      arm_tx     <= next_arm_tx;
      arm_mf     <= next_arm_mf;
      prdata     <= next_prdata;
      pready     <= next_pready;
      pslverr    <= next_pslverr;
      irq        <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // pin multiplexing
  // ----------------------------------------------------------------
  // an enable of zero hands the pin back to general-purpose port logic
  always_comb begin
    next_sck.o   = cpol ^ sck_lvl;
    next_sck.oe  = en && mst;
    next_mosi.o  = out_bit;
    next_mosi.oe = en && mst && (!sws || bidir);
    next_miso.o  = out_bit;
    next_miso.oe = en && !mst && (sws ? bidir : !ss_q);
    next_ss.o    = (state != st_run);
    next_ss.oe   = en && mst && mfen && main_ctl.select_output_enable;
  end
  // pin drivers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {sck_out, sck_oe}   <= 2'h0;
      {mosi_out, mosi_oe} <= 2'h0;
      {miso_out, miso_oe} <= 2'h0;
      {ss_n_out, ss_n_oe} <= 2'h2;
    end else begin
      {sck_out, sck_oe}   <= next_sck;
      {mosi_out, mosi_oe} <= next_mosi;
      {miso_out, miso_oe} <= next_miso;
      {ss_n_out, ss_n_oe} <= next_ss;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // gap between master clock edges, counted in running cycles only
  logic [10:0] gap;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 11'h000;
    end else if (m_edge) begin
      gap <= 11'h001;
    end else if (run_ok) begin
      gap <= gap + 11'h001;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  localparam int RELOAD_WIN = TX_RELOAD_CYC;  // local copy of the reload window
  a_opt_read_zero: assert property (pready && !pwrite && paddr == OFF_OPT |-> prdata[7:5] == 3'h0 && !prdata[2])
    else $error("option register unused bits read nonzero");
  a_opt_write_mask: assert property (acc_fin && pwrite && paddr == OFF_OPT |=> opt == ($past(pwdata[7:0]) & OC_MASK))
    else $error("option write not masked");
  a_stat_read_zero: assert property (pready && !pwrite && paddr == OFF_STAT |-> prdata[6] == 1'b0 && prdata[3:0] == 4'h0)
    else $error("status unused bits read nonzero");
  a_baud_edge_gap: assert property (m_edge && edge_cnt != 4'h0 && $stable(baud) |-> gap == 11'((11'(pre) + 11'h001) << rate))
    else $error("master clock half period wrong");
  a_tx_discard: assert property (acc_fin && pwrite && paddr == OFF_DATA && !arm_tx |=> $stable(tx_buf))
    else $error("unarmed data write was taken");
  a_tx_refill: assert property (acc_fin && pwrite && paddr == OFF_DATA && arm_tx && tx_empty && en && mst
    && state == st_idle && run_ok |-> ##[1:RELOAD_WIN] tx_empty)
    else $error("idle write did not reload tx_empty");
  a_rx_overrun: assert property (eng_done && rx_full && !(acc_fin && paddr == OFF_DATA && arm_rx) |=> $stable(rx_buf))
    else $error("overrun overwrote receive buffer");
  a_rx_set: assert property (eng_done && en |=> rx_full)
    else $error("rx_full not set at transfer end");
  a_mf_never: assert property (!mode_fault && !(mst && mfen && !main_ctl.select_output_enable) |=> !mode_fault)
    else $error("mode_fault set outside fault configuration");
  a_disable_flags: assert property (!en |=> !rx_full && tx_empty && state == st_idle)
    else $error("disable did not reset flags");
  a_irq_tx: assert property (tx_empty && main_ctl.tx_int_enable |=> irq)
    else $error("tx interrupt missing");
  a_single_wire: assert property (en && sws && !bidir |=> !mosi_oe && !miso_oe)
    else $error("shared pin driven with driver off");
  a_ss_release: assert property (en && mst && !mfen |=> !ss_n_oe)
    else $error("select pin not released");
  c_master_xfer: cover property (eng_done && mst);
  c_slave_xfer: cover property (eng_done && !mst);
  c_overrun: cover property (eng_done && rx_full);
  c_mode_fault: cover property ($rose(mode_fault));

endmodule

// ### scd_serial_regs_tb_top.sv
module scd_serial_regs_tb_top
  import scd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, wait_mode = 0, ss_drv = 1, lsbf = 0;
  logic [7:0]  paddr = 8'h00, reply = 8'h00, r, got, frames;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, err, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic        ss_n_out, ss_n_oe, irq, pm_miso, sck_q = 0;
  int          num_errors = 0, comparisons = 0, cyc = 0, cnt = 0, gap = 0;
  wire logic   sck_w  = sck_oe ? sck_out : 1'b0;
  wire logic   ss_w   = ss_n_oe ? ss_n_out : ss_drv;
  wire logic   miso_w = miso_oe ? miso_out : pm_miso;

  always #4 pclk = ~pclk;

  scd_serial_regs u_scd_serial_regs (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wait_mode(wait_mode),
    .sck_in(1'b0), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_out), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_w),
    .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe), .irq(irq)
  );

  scd_slave_model u_scd_slave_model (
    .sck(sck_w), .sel_n(ss_w), .lsbf(lsbf), .reply(reply), .mosi(mosi_out), .miso(pm_miso),
    .got(got), .frames(frames)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    if (num_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // one apb transfer; request held until pready seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    r = prdata[7:0];
    err = pslverr;
    chk(8'(n), 8'h02, "wait states");
    psel <= 0;
    penable <= 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string m);
    apb(1'b0, a, 8'h00);
    chk(r, e, m);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic wait_frames(input logic [7:0] n);
    int k;
    k = 0;
    while (frames !== n && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    chk(frames, n, "frame count");
  endtask

  // half-period monitor on the serial clock, plus run limit
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    sck_q <= sck_out;
    if (sck_out !== sck_q) begin
      gap <= cnt;
      cnt <= 1;
    end else begin
      cnt <= cnt + 1;
    end
    if (cyc == 60000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int i, pre, rate;
    logic [7:0] a, b, bv, f0, v;
    logic ti;
    void'($urandom(66));
    repeat (3) @(posedge pclk);
    presetn <= 1;
    rd(OFF_MAIN, MAIN_RST, "main reset");
    rd(OFF_OPT, OPT_RST, "option reset");
    rd(OFF_BAUD, BAUD_RST, "baud reset");
    // master without fault enable; write with no status read first
    wr(OFF_MAIN, 8'h52);
    repeat (2) @(posedge pclk);
    chk({7'h0, ss_n_oe}, 8'h00, "select pin freed");
    wr(OFF_DATA, 8'h5A);
    repeat (60) @(posedge pclk);
    rd(OFF_STAT, 8'h20, "unarmed write");
    wr(OFF_STAT, 8'hFF);
    rd(OFF_STAT, 8'h20, "status write");
    rd(8'h14, 8'h00, "unmapped data");
    chk({7'h0, err}, 8'h01, "unmapped err");
    v = 8'($urandom);
    wr(OFF_OPT, v);
    rd(OFF_OPT, v & OC_MASK, "option mask");
    wr(OFF_OPT, 8'h10);
    // pairs of queued bytes, second one overruns the receiver
    for (i = 0; i < 4; i++) begin
      lsbf = i[0];
      ti = 1'($urandom_range(0, 1));
      pre = $urandom_range(1, 3);
      rate = $urandom_range(0, 2);
      bv = {1'b0, 3'(pre), 1'b0, 3'(rate)};
      a = (i == 3) ? 8'h00 : 8'($urandom);
      b = (i == 3) ? 8'hFF : 8'($urandom);
      reply = 8'($urandom);
      f0 = frames;
      wr(OFF_BAUD, bv);
      wr(OFF_MAIN, {2'b01, ti, 1'b1, 2'b00, 1'b1, lsbf});
      rd(OFF_STAT, 8'h20, "idle status");
      chk({7'h0, ss_n_oe}, 8'h01, "select driven");
      wr(OFF_DATA, a);
      rd(OFF_STAT, 8'h20, "fast reload");
      wr(OFF_DATA, b);
      rd(OFF_STAT, 8'h00, "buffer full");
      wr(OFF_BAUD, bv);
      rd(OFF_BAUD, bv, "baud busy");
      wait_frames(8'(f0 + 8'd2));
      repeat (40) @(posedge pclk);
      chk(got, b, "sent byte");
      chk(8'(gap), 8'((pre + 1) << rate), "half period");
      chk({7'h0, irq}, {7'h0, ti}, "tx irq");
      rd(OFF_STAT, 8'hA0, "after pair");
      rd(OFF_DATA, reply ^ f0, "overrun kept");
      rd(OFF_STAT, 8'h20, "rx cleared");
    end
    // stop in wait freezes the engine until wait ends
    wr(OFF_OPT, 8'h12);
    wait_mode <= 1'b1;
    f0 = frames;
    rd(OFF_STAT, 8'h20, "wait idle");
    wr(OFF_DATA, 8'hC3);
    repeat (300) @(posedge pclk);
    chk(frames, f0, "frozen in wait");
    rd(OFF_STAT, 8'h00, "held in wait");
    wait_mode <= 1'b0;
    wait_frames(8'(f0 + 8'd1));
    repeat (40) @(posedge pclk);
    chk(got, 8'hC3, "wait sent");
    rd(OFF_STAT, 8'hA0, "wait done");
    rd(OFF_DATA, reply ^ f0, "wait byte");
    // disable in mid-transfer
    f0 = frames;
    rd(OFF_STAT, 8'h20, "pre abort");
    wr(OFF_DATA, 8'h3C);
    wr(OFF_MAIN, 8'h00);
    repeat (200) @(posedge pclk);
    chk(frames, f0, "aborted");
    rd(OFF_STAT, 8'h20, "abort flags");
    // mode fault with select pin as fault input
    wr(OFF_MAIN, 8'hD0);
    @(posedge pclk);
    ss_drv <= 0;
    repeat (4) @(posedge pclk);
    ss_drv <= 1;
    rd(OFF_STAT, 8'h30, "fault set");
    chk({7'h0, irq}, 8'h01, "fault irq");
    wr(OFF_MAIN, 8'hD0);
    rd(OFF_STAT, 8'h20, "fault cleared");
    chk({7'h0, irq}, 8'h00, "irq drop");
    tally_and_finish();
  end
endmodule

// ### scd_slave_model.sv
module scd_slave_model (
  input  wire logic       sck,
  input  wire logic       sel_n,
  input  wire logic       lsbf,
  input  wire logic [7:0] reply,
  input  wire logic       mosi,
  output logic            miso,
  output logic [7:0]      got,
  output logic [7:0]      frames
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh_out;
  logic [7:0] sh_in;
  int         nb;

  // ----------------------------------------------------------------
  // far-side slave, clock format with first edge mid-bit
  // ----------------------------------------------------------------
  initial begin
    miso = 1'b1;
    got = 8'h00;
    frames = 8'h00;
    sh_in = 8'h00;
    nb = 0;
  end

  // reply differs per frame so an overrun shows which byte was kept
  task automatic load;
    sh_out = reply ^ frames;
    nb = 0;
    miso = lsbf ? sh_out[0] : sh_out[7];
  endtask

  always @(negedge sel_n) load();

  // sample on rising edge, eight bits a frame
  always @(posedge sck) begin
    if (!sel_n) begin
      sh_in = lsbf ? {mosi, sh_in[7:1]} : {sh_in[6:0], mosi};
      nb++;
      if (nb == 8) begin
        got = sh_in;
        frames++;
        load();
      end
    end
  end

  // next bit out on falling edge
  always @(negedge sck) begin
    if (!sel_n && nb != 0) begin
      sh_out = lsbf ? sh_out >> 1 : sh_out << 1;
      miso = lsbf ? sh_out[0] : sh_out[7];
    end
  end

  // released line must not keep showing the last bit
  always @(posedge sel_n) miso = ~miso;
endmodule
